/* design/cmb_top.sv */
// CAN message buffer RAM with identifier-word fetch engine.
// Assumes CPU port, region settings and fetch requests come from same-clock logic.
//
// Summary of operation
// - Buffer words fetched from data RAM, not registers
// - Software sets region base and size; fetch relative
// - Word0 bits 15-13, word1 bits 15-12 read zero
// - Word1 bits 11-0 hold extended ID 17-6
// - Identifier bits read/write, undefined after power-on
`timescale 1ns/100ps
module cmb_top #(
    parameter int RAM_AW = 6                         // RAM address width in words
) (
    input  wire logic                              i_clock,        // 20 MHz system clock
    input  wire logic                              i_arst_n,       // Async reset, active low
    input  wire logic [RAM_AW-1:0]                 i_cpu_addr,     // CPU word address
    input  wire logic                              i_cpu_wr,       // CPU write strobe
    input  wire logic                              i_cpu_rd,       // CPU read strobe
    input  wire logic [cmb_pkg::CMB_DATA_W-1:0]    i_cpu_wdata,    // CPU write data
    output logic      [cmb_pkg::CMB_DATA_W-1:0]    o_cpu_rdata,    // CPU read data
    output logic                                   o_cpu_rvalid,   // Read data valid pulse
    input  wire logic [RAM_AW-1:0]                 i_region_base,  // Buffer region base word
    input  wire logic [RAM_AW-cmb_pkg::CMB_STRIDE_LOG:0] i_region_count, // Buffers in region
    input  wire logic                              i_fetch_req,    // Fetch request pulse
    input  wire logic [RAM_AW-cmb_pkg::CMB_STRIDE_LOG:0] i_fetch_idx,    // Buffer index
    output logic                                   o_fetch_busy,   // Engine busy
    output logic                                   o_fetch_err,    // Index outside region pulse
    output logic                                   o_hdr_valid,    // Header available
    input  wire logic                              i_hdr_ready,    // Header consumer ready
    output logic                                   o_hdr_ide,      // Extended frame
    output logic                                   o_hdr_rtr,      // Remote request
    output logic                                   o_hdr_srr_err,  // Extended with SRR clear
    output logic [cmb_pkg::CMB_BASE_W-1:0]         o_hdr_base_identifier,      // Base ID
    output logic [cmb_pkg::CMB_EIDH_W-1:0]         o_hdr_extended_identifier_upper // Extended ID 17-6
);
    import cmb_pkg::*;

    localparam int SL         = CMB_STRIDE_LOG;
    localparam int RAM_WORDS  = 1 << RAM_AW;

    // Buffer RAM, no reset: contents undefined after power-on
    logic [CMB_DATA_W-1:0] mem_reg [RAM_WORDS];

    cmb_state_type         state_reg;
    cmb_state_type         state_next;
    logic [RAM_AW-1:0]     addr_reg;
    logic [CMB_DATA_W-1:0] w0_reg;
    logic [CMB_DATA_W-1:0] w1_reg;
    logic                  busy_reg;
    logic                  err_reg;
    logic [CMB_DATA_W-1:0] rdata_reg;
    logic                  rvalid_reg;
    cmb_hdr_type           out_reg;
    logic                  out_valid_reg;

    cmb_stream_if #(.WIDTH(CMB_HDR_W)) push_if ();
    cmb_stream_if #(.WIDTH(CMB_HDR_W)) pop_if ();

    // Region decode for CPU reads
    wire [RAM_AW:0]     region_span = {i_region_count, {SL{1'b0}}};
    wire [RAM_AW-1:0]   cpu_off     = i_cpu_addr - i_region_base;
    wire                cpu_in_reg  = ({1'b0, cpu_off} < region_span);
    wire [SL-1:0]       cpu_word    = cpu_off[SL-1:0];
    wire                cpu_is_w0   = cpu_in_reg && (cpu_word == CMB_WORD0[SL-1:0]);
    wire                cpu_is_w1   = cpu_in_reg && (cpu_word == CMB_WORD1[SL-1:0]);
    wire [CMB_DATA_W-1:0] cpu_mask  = cpu_is_w0 ? CMB_WORD0_MASK :
                                      cpu_is_w1 ? CMB_WORD1_MASK :
                                      CMB_PLAIN_MASK;
    wire [CMB_DATA_W-1:0] cpu_ram_data = mem_reg[i_cpu_addr];

    // Fetch address decode
    wire                idx_ok      = (i_fetch_idx < i_region_count);
    wire [RAM_AW-1:0]   fetch_addr  = i_region_base + RAM_AW'({i_fetch_idx, {SL{1'b0}}});
    wire                accept      = (state_reg == CMB_ST_IDLE) && i_fetch_req && idx_ok;
    wire                reject      = (state_reg == CMB_ST_IDLE) && i_fetch_req && !idx_ok;
    wire [RAM_AW-1:0]   rd_addr     = (state_reg == CMB_ST_WORD1) ? addr_reg + 1'b1 : addr_reg;
    wire [CMB_DATA_W-1:0] ram_rd_data = mem_reg[rd_addr];

    // Header decode from the fetched words
    wire                hdr_ide     = w0_reg[CMB_IDE_BIT];
    wire                hdr_srr     = w0_reg[CMB_SRR_BIT];
    cmb_hdr_type        push_hdr;
    assign push_hdr.ide             = hdr_ide;
    assign push_hdr.rtr             = !hdr_ide && hdr_srr;
    assign push_hdr.srr_err         = hdr_ide && !hdr_srr;
    assign push_hdr.base_identifier = w0_reg[CMB_BASE_MSB:CMB_BASE_LSB];
    // Standard frames carry no extension, so the field is forced quiet
    assign push_hdr.extended_identifier_upper =
        hdr_ide ? w1_reg[CMB_EIDH_MSB:0] : '0;

    assign push_if.data  = push_hdr;
    assign push_if.valid = (state_reg == CMB_ST_PUSH);
    assign pop_if.ready  = !out_valid_reg || i_hdr_ready;

    cmb_fifo #(
        .WIDTH (CMB_HDR_W),
        .DEPTH (CMB_FIFO_DEPTH)
    ) u_fifo (
        .i_clock  (i_clock),
        .i_arst_n (i_arst_n),
        .s_in     (push_if),
        .s_out    (pop_if)
    );

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            CMB_ST_IDLE: begin
                if (accept) state_next = CMB_ST_WORD0;
            end
            CMB_ST_WORD0: begin
                state_next = CMB_ST_WORD1;
            end
            CMB_ST_WORD1: begin
                state_next = CMB_ST_PUSH;
            end
            CMB_ST_PUSH: begin
                // Stalls here while the FIFO is full
                if (push_if.ready) state_next = CMB_ST_IDLE;
            end
        endcase
    end

    // Direct software writes; bits are stored as given
    always_ff @(posedge i_clock) begin
        if (i_cpu_wr) begin
            mem_reg[i_cpu_addr] <= i_cpu_wdata;
        end
    end

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rdata_reg  <= '0;
            rvalid_reg <= 1'b0;
        end else begin
            rvalid_reg <= i_cpu_rd;
            if (i_cpu_rd) rdata_reg <= cpu_ram_data & cpu_mask;
        end
    end

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state_reg <= CMB_ST_IDLE;
            busy_reg  <= 1'b0;
            err_reg   <= 1'b0;
            addr_reg  <= '0;
        end else begin
            state_reg <= state_next;
            busy_reg  <= (state_next != CMB_ST_IDLE);
            err_reg   <= reject;
            if (accept) addr_reg <= fetch_addr;
        end
    end

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            w0_reg <= '0;
            w1_reg <= '0;
        end else begin
            if (state_reg == CMB_ST_WORD0) w0_reg <= ram_rd_data;
            if (state_reg == CMB_ST_WORD1) w1_reg <= ram_rd_data;
        end
    end

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            out_reg       <= '0;
            out_valid_reg <= 1'b0;
        end else if (pop_if.valid && pop_if.ready) begin
            out_reg       <= pop_if.data;
            out_valid_reg <= 1'b1;
        end else if (i_hdr_ready) begin
            out_valid_reg <= 1'b0;
        end
    end

    assign o_cpu_rdata                     = rdata_reg;
    assign o_cpu_rvalid                    = rvalid_reg;
    assign o_fetch_busy                    = busy_reg;
    assign o_fetch_err                     = err_reg;
    assign o_hdr_valid                     = out_valid_reg;
    assign o_hdr_ide                       = out_reg.ide;
    assign o_hdr_rtr                       = out_reg.rtr;
    assign o_hdr_srr_err                   = out_reg.srr_err;
    assign o_hdr_base_identifier           = out_reg.base_identifier;
    assign o_hdr_extended_identifier_upper = out_reg.extended_identifier_upper;

    // Checks
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_arst_n);

    sequence s_fetch_words;
        (state_reg == CMB_ST_WORD0) ##1 (state_reg == CMB_ST_WORD1) ##1
        (state_reg == CMB_ST_PUSH);
    endsequence

    sequence s_write_then_read;
        i_cpu_wr ##1 (i_cpu_rd && !i_cpu_wr && i_cpu_addr == $past(i_cpu_addr));
    endsequence

    // Read strobe answered exactly one edge later
    sequence s_cpu_read;
        i_cpu_rd ##1 o_cpu_rvalid;
    endsequence

    AST_FETCH_FROM_RAM: assert property (
        (state_reg == CMB_ST_WORD0) |=> (w0_reg == $past(ram_rd_data)))
        else $error("Word 0 not taken from buffer RAM");

    AST_REGION_ADDRESS: assert property (
        accept |=> (addr_reg == $past(fetch_addr)) && (state_reg == CMB_ST_WORD0) && busy_reg)
        else $error("Fetch not addressed relative to region base");

    AST_REGION_REJECT: assert property (
        reject |=> o_fetch_err && (state_reg == CMB_ST_IDLE) ##1 !o_fetch_err)
        else $error("Out of region index not rejected as one pulse");

    AST_UNIMPL_ZERO: assert property (
        (i_cpu_rd && cpu_is_w0) |=> (o_cpu_rdata[15:13] == 3'h0) && o_cpu_rvalid)
        else $error("Word 0 upper bits not read as zero");

    AST_UNIMPL_ZERO_W1: assert property (
        (i_cpu_rd && cpu_is_w1) |=> (o_cpu_rdata[15:12] == 4'h0))
        else $error("Word 1 upper bits not read as zero");

    AST_EXT_UPPER: assert property (
        s_fetch_words |-> (!hdr_ide ||
            push_hdr.extended_identifier_upper == $past(ram_rd_data[CMB_EIDH_MSB:0], 1)))
        else $error("Extended identifier upper bits misplaced");

    AST_FRAME_FORMAT: assert property (
        s_fetch_words |-> (push_hdr.ide == $past(ram_rd_data[CMB_IDE_BIT], 2)) &&
            (push_hdr.base_identifier == $past(ram_rd_data[CMB_BASE_MSB:CMB_BASE_LSB], 2)))
        else $error("Frame format or base identifier wrong");

    AST_REMOTE_REQUEST: assert property (
        (pop_if.valid && pop_if.ready) |=>
            (o_hdr_rtr == (!o_hdr_ide && $past(pop_if.data[CMB_HDR_W-2]))) && o_hdr_valid)
        else $error("Remote request flag wrong at output");

    AST_READ_BACK: assert property (
        s_write_then_read |=> (o_cpu_rdata == ($past(i_cpu_wdata, 2) & $past(cpu_mask))))
        else $error("Written identifier bits not read back");

    // Second word and the full walk of the engine
    AST_FETCH_WORD1_RAM: assert property (
        (state_reg == CMB_ST_WORD1) |=> (w1_reg == $past(ram_rd_data)))
        else $error("Word 1 not taken from buffer RAM");

    AST_FETCH_SEQUENCE: assert property (
        accept |=> s_fetch_words)
        else $error("Accepted fetch did not read both words in order");

    // Word 1 sits one above word 0, wrapping with the address space
    AST_WORD1_ADDRESS: assert property (
        (state_reg == CMB_ST_WORD1) |-> (rd_addr == RAM_AW'(addr_reg + 1'b1)))
        else $error("Word 1 not read next to word 0");

    // Requests landing mid-fetch are dropped silently, not rejected
    AST_BUSY_IGNORES: assert property (
        (i_fetch_req && (state_reg != CMB_ST_IDLE)) |=>
            !o_fetch_err && (addr_reg == $past(addr_reg)))
        else $error("Request while busy disturbed the fetch");

    AST_ERR_ONLY_REJECT: assert property (
        o_fetch_err |-> $past(reject))
        else $error("Error pulse without an out of region request");

    AST_STD_EXT_QUIET: assert property (
        s_fetch_words |-> (hdr_ide || (push_hdr.extended_identifier_upper == '0)))
        else $error("Standard frame carried an extension field");

    AST_SRR_SLIP: assert property (
        s_fetch_words |-> (push_hdr.srr_err ==
            ($past(ram_rd_data[CMB_IDE_BIT], 2) && !$past(ram_rd_data[CMB_SRR_BIT], 2))))
        else $error("Extended frame with SRR clear not flagged");

    // A stalled push must not let the offered header drift
    AST_PUSH_STALL: assert property (
        (push_if.valid && !push_if.ready) |=>
            (state_reg == CMB_ST_PUSH) && $stable(push_hdr))
        else $error("Header changed while the FIFO was full");

    AST_HDR_HOLD: assert property (
        (o_hdr_valid && !i_hdr_ready) |=> o_hdr_valid && $stable(out_reg))
        else $error("Header output dropped before it was taken");

    // Valid is a one-cycle echo of the read strobe
    AST_READ_PULSE: assert property (
        i_cpu_rd |-> s_cpu_read)
        else $error("Read data valid missing one cycle after read");

    AST_NO_STRAY_RVALID: assert property (
        !i_cpu_rd |=> !o_cpu_rvalid)
        else $error("Read data valid without a read");

    AST_PLAIN_READ: assert property (
        (i_cpu_rd && !cpu_is_w0 && !cpu_is_w1) |=> (o_cpu_rdata == $past(cpu_ram_data)))
        else $error("Plain word not read back unmasked");
endmodule

/* design/cmb_pkg.sv */
// Package for the CAN message buffer store and identifier fetch engine.
// Assumes one clock domain; buffers live in a word-addressed 16-bit RAM.
package cmb_pkg;

    localparam int          CMB_DATA_W     = 16;
    localparam int          CMB_STRIDE_LOG = 3;          // Eight RAM words per buffer
    localparam int          CMB_FIFO_DEPTH = 4;

    // Word index within one buffer
    localparam logic [2:0]  CMB_WORD0      = 3'h0;
    localparam logic [2:0]  CMB_WORD1      = 3'h1;

    // Read masks: unimplemented upper bits read as zero
    localparam logic [15:0] CMB_WORD0_MASK = 16'h1fff;
    localparam logic [15:0] CMB_WORD1_MASK = 16'h0fff;
    localparam logic [15:0] CMB_PLAIN_MASK = 16'hffff;

    // Word 0 field layout
    localparam int          CMB_IDE_BIT    = 0;
    localparam int          CMB_SRR_BIT    = 1;
    localparam int          CMB_BASE_LSB   = 2;
    localparam int          CMB_BASE_MSB   = 12;
    localparam int          CMB_BASE_W     = 11;

    // Word 1 field layout
    localparam int          CMB_EIDH_MSB   = 11;
    localparam int          CMB_EIDH_W     = 12;

    typedef enum logic [1:0] {
        CMB_ST_IDLE,
        CMB_ST_WORD0,
        CMB_ST_WORD1,
        CMB_ST_PUSH
    } cmb_state_type;

    typedef struct packed {
        logic                  ide;
        logic                  rtr;
        logic                  srr_err;
        logic [CMB_BASE_W-1:0] base_identifier;
        logic [CMB_EIDH_W-1:0] extended_identifier_upper;
    } cmb_hdr_type;

    localparam int          CMB_HDR_W      = $bits(cmb_hdr_type);

endpackage

/* design/cmb_stream_if.sv */
// Valid/ready stream carrier between the fetch engine and its FIFO.
// Assumes both ends share one clock.
`timescale 1ns/100ps
interface cmb_stream_if #(
    parameter int WIDTH = 8
);
    logic [WIDTH-1:0] data;
    logic             valid;
    logic             ready;

    modport src (output data, output valid, input ready);
    modport snk (input data, input valid, output ready);
endinterface

/* design/cmb_fifo.sv */
// Flip-flop FIFO with valid/ready on both sides.
// Assumes the drain side may stall; full then drops ready on the fill side.
`timescale 1ns/100ps
module cmb_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input  wire logic  i_clock,   // System clock
    input  wire logic  i_arst_n,  // Async reset, active low
    cmb_stream_if.snk  s_in,      // Fill side
    cmb_stream_if.src  s_out      // Drain side
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [PW:0]   FULL_COUNT = (PW+1)'(DEPTH);
    localparam logic [PW-1:0] LAST_PTR   = PW'(DEPTH - 1);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [PW-1:0]    wr_ptr_reg;
    logic [PW-1:0]    rd_ptr_reg;
    logic [PW:0]      count_reg;

    wire push = s_in.valid && s_in.ready;
    wire pop  = s_out.valid && s_out.ready;
    wire [PW-1:0] wr_ptr_next = (wr_ptr_reg == LAST_PTR) ? '0 : wr_ptr_reg + 1'b1;
    wire [PW-1:0] rd_ptr_next = (rd_ptr_reg == LAST_PTR) ? '0 : rd_ptr_reg + 1'b1;

    assign s_in.ready  = (count_reg != FULL_COUNT);
    assign s_out.valid = (count_reg != '0);
    assign s_out.data  = mem_reg[rd_ptr_reg];

    always_ff @(posedge i_clock) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= s_in.data;
        end
    end

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end else begin
            if (push) wr_ptr_reg <= wr_ptr_next;
            if (pop)  rd_ptr_reg <= rd_ptr_next;
            if (push && !pop) count_reg <= count_reg + 1'b1;
            else if (pop && !push) count_reg <= count_reg - 1'b1;
        end
    end

    AST_FIFO_FULL_STALLS: assert property (@(posedge i_clock) disable iff (!i_arst_n)
        (count_reg == FULL_COUNT && !pop) |=> (count_reg == FULL_COUNT) &&
            (wr_ptr_reg == $past(wr_ptr_reg)))
        else $error("FIFO full but fill side still taken");

    AST_FIFO_COUNT_UP: assert property (@(posedge i_clock) disable iff (!i_arst_n)
        (push && !pop) |=> (count_reg == $past(count_reg) + 1'b1))
        else $error("FIFO count did not follow a lone push");
endmodule

/* verif/cmb_hdr_sink.sv */
// Header consumer model standing at the far side of the fetch engine.
// Assumes the bench picks prompt or slow acceptance through i_slow.
`timescale 1ns/100ps
module cmb_hdr_sink (
    input  wire logic i_clock,   // System clock
    input  wire logic i_arst_n,  // Async reset, active low
    input  wire logic i_slow,    // Accept one cycle in eight
    output logic      o_ready    // Header ready
);
    logic [2:0] pace_reg;
    logic       ready_reg;

    // Registered so ready is settled mid-cycle; slow pacing backs up the FIFO
    assign o_ready = ready_reg;

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            pace_reg  <= 3'h0;
            ready_reg <= 1'b0;
        end else begin
            pace_reg  <= pace_reg + 3'h1;
            ready_reg <= !i_slow || (pace_reg == 3'h6);
        end
    end
endmodule

/* verif/cmb_top_tb.sv */
// Self-checking bench for the message buffer store and fetch engine.
// Assumes the RAM model here mirrors every CPU write made by the bench.
`timescale 1ns/100ps
module cmb_top_tb;
    import cmb_pkg::*;
    localparam int AW = 6;
    localparam int CW = AW - CMB_STRIDE_LOG + 1;

    logic                i_clock, i_arst_n, i_cpu_wr, i_cpu_rd, i_fetch_req, slow;
    logic [AW-1:0]       i_cpu_addr, i_region_base;
    logic [CW-1:0]       i_region_count, i_fetch_idx;
    logic [15:0]         i_cpu_wdata, o_cpu_rdata;
    logic                o_cpu_rvalid, o_fetch_busy, o_fetch_err, o_hdr_valid, i_hdr_ready;
    logic                o_hdr_ide, o_hdr_rtr, o_hdr_srr_err;
    logic [CMB_BASE_W-1:0] o_hdr_base_identifier;
    logic [CMB_EIDH_W-1:0] o_hdr_extended_identifier_upper;
    logic [15:0]         mem [64];
    cmb_hdr_type         exp_q [$];
    logic [31:0]         r;
    int                  base, cnt, n_errors, samples_checked;

    cmb_top #(.RAM_AW(AW)) cmb_top_inst (
        .i_clock(i_clock), .i_arst_n(i_arst_n), .i_cpu_addr(i_cpu_addr),
        .i_cpu_wr(i_cpu_wr), .i_cpu_rd(i_cpu_rd), .i_cpu_wdata(i_cpu_wdata),
        .o_cpu_rdata(o_cpu_rdata), .o_cpu_rvalid(o_cpu_rvalid),
        .i_region_base(i_region_base), .i_region_count(i_region_count),
        .i_fetch_req(i_fetch_req), .i_fetch_idx(i_fetch_idx), .o_fetch_busy(o_fetch_busy),
        .o_fetch_err(o_fetch_err), .o_hdr_valid(o_hdr_valid), .i_hdr_ready(i_hdr_ready),
        .o_hdr_ide(o_hdr_ide), .o_hdr_rtr(o_hdr_rtr), .o_hdr_srr_err(o_hdr_srr_err),
        .o_hdr_base_identifier(o_hdr_base_identifier),
        .o_hdr_extended_identifier_upper(o_hdr_extended_identifier_upper));

    cmb_hdr_sink cmb_hdr_sink_inst (
        .i_clock(i_clock), .i_arst_n(i_arst_n), .i_slow(slow), .o_ready(i_hdr_ready));

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic conclude;
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic wr(input int a, input logic [15:0] d);
        @(negedge i_clock);
        i_cpu_wr = 1'b1;
        i_cpu_addr = a[AW-1:0];
        i_cpu_wdata = d;
        mem[a % 64] = d;
        @(negedge i_clock);
        i_cpu_wr = 1'b0;
    endtask

    task automatic rd(input int a, input logic [15:0] mask);
        @(negedge i_clock);
        i_cpu_rd = 1'b1;
        i_cpu_addr = a[AW-1:0];
        @(negedge i_clock);
        i_cpu_rd = 1'b0;
        check("cpu_rvalid", 32'h1, {31'h0, o_cpu_rvalid});
        check("cpu_rdata", {16'h0, mem[a % 64] & mask}, {16'h0, o_cpu_rdata});
    endtask

    // Write then read the same word on the very next edge
    task automatic wr_rd(input int a, input logic [15:0] d, input logic [15:0] mask);
        @(negedge i_clock);
        i_cpu_wr = 1'b1;
        i_cpu_addr = a[AW-1:0];
        i_cpu_wdata = d;
        mem[a % 64] = d;
        @(negedge i_clock);
        i_cpu_wr = 1'b0;
        i_cpu_rd = 1'b1;
        @(negedge i_clock);
        i_cpu_rd = 1'b0;
        check("cpu_rvalid", 32'h1, {31'h0, o_cpu_rvalid});
        check("cpu_rdata", {16'h0, mem[a % 64] & mask}, {16'h0, o_cpu_rdata});
    endtask

    task automatic fetch(input int idx);
        logic [15:0] w0, w1;
        cmb_hdr_type h;
        @(negedge i_clock);
        i_fetch_req = 1'b1;
        i_fetch_idx = idx[CW-1:0];
        @(negedge i_clock);
        if (idx >= cnt) begin
            i_fetch_req = 1'b0;
            check("fetch_err", 32'h1, {31'h0, o_fetch_err});
        end else begin
            // Held request lands while busy and must be dropped
            i_fetch_idx = ~idx[CW-1:0];
            check("fetch_err", 32'h0, {31'h0, o_fetch_err});
            check("fetch_busy", 32'h1, {31'h0, o_fetch_busy});
            w0 = mem[(base + 8 * idx) % 64];
            w1 = mem[(base + 8 * idx + 1) % 64];
            h.ide = w0[0];
            h.rtr = !w0[0] && w0[1];
            h.srr_err = w0[0] && !w0[1];
            h.base_identifier = w0[12:2];
            h.extended_identifier_upper = w0[0] ? w1[11:0] : 12'h000;
            exp_q.push_back(h);
            @(negedge i_clock);
            i_fetch_req = 1'b0;
            for (int n = 0; n < 400 && o_fetch_busy !== 1'b0; n++) @(negedge i_clock);
            check("busy_end", 32'h0, {31'h0, o_fetch_busy});
        end
    endtask

    // Mid-cycle: valid and ready are settled for the edge that takes the header
    always @(negedge i_clock) begin
        if (i_arst_n && o_hdr_valid === 1'b1 && i_hdr_ready === 1'b1) begin
            if (exp_q.size() == 0) begin
                check("hdr_extra", 32'h0, 32'h1);
            end else begin
                check("header", {6'h0, exp_q.pop_front()}, {6'h0, o_hdr_ide, o_hdr_rtr,
                    o_hdr_srr_err, o_hdr_base_identifier, o_hdr_extended_identifier_upper});
            end
        end
    end

    initial begin
        i_clock = 1'b0;
        forever #25 i_clock = ~i_clock;
    end

    initial begin
        #(50 * 20000);
        n_errors++;
        conclude();
    end

    initial begin
        {i_arst_n, i_cpu_wr, i_cpu_rd, i_fetch_req, slow} = 5'h00;
        {i_cpu_addr, i_region_base, i_region_count, i_fetch_idx, i_cpu_wdata} = '0;
        n_errors = 0;
        samples_checked = 0;
        r = $urandom(32'h6c67a1c2);
        repeat (5) @(negedge i_clock);
        i_arst_n = 1'b1;
        base = $urandom % 64;
        cnt = 4;
        i_region_base = base[AW-1:0];
        i_region_count = cnt[CW-1:0];
        // Word 0 low bits walk all four SRR and IDE combinations
        for (int i = 0; i < 4; i++) begin
            r = $urandom;
            wr(base + 8 * i, {r[15:2], i[1:0]});
            wr(base + 8 * i + 1, r[31:16]);
            wr(base + 8 * i + 2, r[15:0] ^ 16'h5a5a);
            rd(base + 8 * i, CMB_WORD0_MASK);
            rd(base + 8 * i + 1, CMB_WORD1_MASK);
            rd(base + 8 * i + 2, CMB_PLAIN_MASK);
            wr_rd(base + 8 * i + 3, r[15:0] ^ r[31:16], CMB_PLAIN_MASK);
        end
        for (int i = 0; i < 4; i++) fetch(i);
        cnt = 2;
        i_region_count = cnt[CW-1:0];
        fetch(2);
        fetch(15);
        base = base + 16;
        i_region_base = base[AW-1:0];
        fetch(0);
        fetch(1);
        slow = 1'b1;
        repeat (14) fetch($urandom % 2);
        for (int n = 0; n < 400 && exp_q.size() != 0; n++) @(negedge i_clock);
        slow = 1'b0;
        check("queue_drained", 32'h0, exp_q.size());
        conclude();
    end
endmodule
